// ---- src/add_shift_datapath.sv ----
/*
 execution datapath for add, and, shift and pointer offset instructions.
 assumes the core presents one instruction per cycle with instr_valid, supplies the
 addressed file register on file_rdata combinationally, and honours stall.
 the core keeps instr and file_rdata steady through a stall cycle; a word offered
 while stall is high is dropped. undecoded words finish nothing and raise no done.
*/
// Notes on behaviour
// RULE1: pointer offset adds sign-extended 6-bit literal to pointer 0 or 1, flags untouched.
// RULE2: pointer sum kept at 16 bits, wrapping modulo 65536.
// RULE3: acc plus literal adds 8-bit immediate into accumulator, updating C, DC, Z.
// RULE4: acc plus file adds accumulator and file register 0..127, updating C, DC, Z.
// RULE5: destination bit 0 writes accumulator, 1 writes back the file register.
// RULE6: add with carry sums accumulator, file register and carry flag.
// RULE7: acc and literal ANDs immediate into accumulator, only zero flag changes.
// RULE8: acc and file ANDs, routes by destination bit, only zero flag changes.
// RULE9: shift right moves file bit 0 into carry, updates carry and zero.
// RULE10: shift right keeps original bit 7 as result bit 7.
// RULE11: zero set on zero result; digit carry is carry out of bit 3.
// RULE12: acc plus literal decoded from upper six bits 111110, one cycle.
// RULE13: pointer offset decoded from 1100010, pointer bit, 6-bit literal, one cycle.
// RULE14: acc and literal decoded from upper six bits 111001.
// RULE15: file op on indirect port costs one extra cycle when pointer MSb set.
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module add_shift_datapath
    import alu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // instruction
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    // file register read data
    input wire logic [7:0] file_rdata,
    // file register write and core status
    output file_wr_s file_wr,
    output logic [7:0] accumulator,
    output flags_s flags,
    output logic [15:0] indirect_pointer_0,
    output logic [15:0] indirect_pointer_1,
    output logic stall,
    output logic done
);
    typedef enum logic {st_run, st_extra} phase_e;

    typedef struct packed {
        phase_e phase;
        logic [7:0] acc;
        flags_s flags;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        file_wr_s wr;
        logic stall;
        logic done;
        logic [13:0] held;
    } state_s;

    state_s state, next_state;
    alu_op_e op;
    logic [7:0] operand_b;
    logic is_file;
    logic dest_file;
    logic [6:0] faddr;
    logic [15:0] ofs;
    logic [13:0] word;
    logic extra_needed;
    alu_result_s res;

    // one flag per opcode; the codes never overlap, so their order is free
    logic live;
    logic hit_add_lit;
    logic hit_and_lit;
    logic hit_ptr_ofs;
    logic hit_add_file;
    logic hit_addc_file;
    logic hit_and_file;
    logic hit_asr_file;
    logic to_file;

    // indirect port test and pointer sum
    logic ind_sel0;
    logic ind_sel1;
    logic [15:0] ptr_base;
    logic [16:0] ptr_sum;

    always_comb begin
        word = (state.phase == st_extra) ? state.held : instr;
        // during the extra cycle the held word runs and the offered one is ignored
        live = instr_valid || (state.phase == st_extra);
        op = op_none;
        operand_b = word[7:0];
        dest_file = word[7];
        faddr = word[6:0];
        // RULE1 sign extension of literal
        ofs = {{10{word[5]}}, word[5:0]};
        // RULE12 add literal decode
        hit_add_lit = live && (word[13:8] == `ALU_OPC_ADDLIT);
        // RULE14 and literal decode
        hit_and_lit = live && (word[13:8] == `ALU_OPC_ANDLIT);
        // RULE13 pointer offset decode
        hit_ptr_ofs = live && (word[13:7] == `ALU_OPC_PTROFS);
        // RULE4 add file decode
        hit_add_file = live && (word[13:8] == `ALU_OPC_ADDF);
        // RULE6 add with carry decode
        hit_addc_file = live && (word[13:8] == `ALU_OPC_ADDFC);
        // RULE8 and file decode
        hit_and_file = live && (word[13:8] == `ALU_OPC_ANDF);
        // RULE9 shift right decode
        hit_asr_file = live && (word[13:8] == `ALU_OPC_ARITH_SHIFT_RIGHT_OP);
        is_file = hit_add_file || hit_addc_file || hit_and_file || hit_asr_file;
        if (hit_add_lit || hit_add_file) begin
            op = op_add;
        end
        else if (hit_addc_file) begin
            op = op_addc;
        end
        else if (hit_and_lit || hit_and_file) begin
            op = op_and;
        end
        else if (hit_asr_file) begin
            op = op_asr;
        end
        else if (hit_ptr_ofs) begin
            op = op_ptr;
        end
        // file data replaces the literal byte only for file operations
        if (is_file) begin
            operand_b = file_rdata;
        end
        // RULE5 destination bit only counts for file operations
        to_file = is_file && dest_file;
        // RULE15 indirect port with pointer MSb
        ind_sel0 = (faddr == `ALU_IND_ADDR0) && state.ptr0[15];
        ind_sel1 = (faddr == `ALU_IND_ADDR1) && state.ptr1[15];
        extra_needed = is_file && (state.phase == st_run) && (ind_sel0 || ind_sel1);
        // RULE2 carry out of bit 15 is dropped on purpose
        ptr_base = word[6] ? state.ptr1 : state.ptr0;
        ptr_sum = {1'b0, ptr_base} + {1'b0, ofs};
    end

    byte_alu i_byte_alu (
        .op(op),
        .a(state.acc),
        .b(operand_b),
        .flags_in(state.flags),
        .result(res)
    );

    always_comb begin
        next_state = state;
        next_state.wr.we = 1'b0;
        next_state.done = 1'b0;
        next_state.stall = 1'b0;
        next_state.phase = st_run;
        if (extra_needed) begin
            // RULE15 hold for one extra cycle
            next_state.phase = st_extra;
            next_state.held = word;
            next_state.stall = 1'b1;
        end
        else if (op == op_ptr) begin
            // RULE2 16-bit wrapping sum
            // RULE1 flags left alone here
            if (word[6]) begin
                next_state.ptr1 = ptr_sum[15:0];
            end
            else begin
                next_state.ptr0 = ptr_sum[15:0];
            end
            next_state.done = 1'b1;
        end
        else if (op != op_none) begin
            // RULE3 RULE7 literal ops target accumulator
            // RULE11 flags from the unit, unaffected ones pass through
            next_state.flags.c = res.flags.c;
            next_state.flags.dc = res.flags.dc;
            next_state.flags.z = res.flags.z;
            next_state.done = 1'b1;
            // RULE5 destination select
            if (to_file) begin
                next_state.wr.we = 1'b1;
                next_state.wr.addr = faddr;
                next_state.wr.data = res.value;
            end
            else begin
                next_state.acc = res.value;
            end
        end
        if (sys_rst) begin
            // reset values spelled out for every field the core reads
            next_state = '0;
            next_state.phase = st_run;
            next_state.acc = `ALU_ACC_RST;
            next_state.flags = `ALU_FLAGS_RST;
            next_state.ptr0 = `ALU_PTR_RST;
            next_state.ptr1 = `ALU_PTR_RST;
            next_state.wr.we = 1'b0;
            next_state.stall = 1'b0;
            next_state.done = 1'b0;
        end
    end

    // reset folded into next_state, so one flop process serves all state
    always_ff @(posedge clk) begin
        state <= next_state;
    end

    // outputs are the registered state; nothing combinational leaks out
    always_comb begin
        file_wr = state.wr;
        accumulator = state.acc;
        flags = state.flags;
        indirect_pointer_0 = state.ptr0;
        indirect_pointer_1 = state.ptr1;
        stall = state.stall;
        done = state.done;
    end
endmodule : add_shift_datapath
`default_nettype wire

// ---- src/alu_cfg.svh ----
/*
 constants for the add and shift datapath: opcode fields, flag positions, reset values.
 assumes inclusion by bare name from the datapath files.
*/
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH
`define ALU_OPC_ADDLIT 6'h3e
`define ALU_OPC_ANDLIT 6'h39
`define ALU_OPC_PTROFS 7'h62
`define ALU_OPC_ADDF 6'h07
`define ALU_OPC_ADDFC 6'h3d
`define ALU_OPC_ANDF 6'h05
`define ALU_OPC_ARITH_SHIFT_RIGHT_OP 6'h37
`define ALU_IND_ADDR0 7'h00
`define ALU_IND_ADDR1 7'h01
`define ALU_ACC_RST 8'h00
`define ALU_PTR_RST 16'h0000
`define ALU_FLAGS_RST 3'h0
`define ALU_FLAG_C 2
`define ALU_FLAG_DC 1
`define ALU_FLAG_Z 0
`endif

// ---- src/alu_pkg.sv ----
/*
 types shared by the add and shift datapath.
 assumes a 14-bit instruction word presented one per cycle.
*/
package alu_pkg;
    typedef enum logic [2:0] {op_none, op_add, op_addc, op_and, op_asr, op_ptr} alu_op_e;
    typedef struct packed {
        logic c;
        logic dc;
        logic z;
    } flags_s;
    typedef struct packed {
        logic [7:0] value;
        flags_s flags;
    } alu_result_s;
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_s;
endpackage : alu_pkg

// ---- src/byte_alu.sv ----
/*
 combinational 8-bit unit: add with optional carry in, and, arithmetic shift right.
 assumes operands are stable within the cycle; has no state.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_alu
    import alu_pkg::*;
(
    // operation and operands
    input wire alu_op_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire flags_s flags_in,
    // result
    output alu_result_s result
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic cin;

    always_comb begin
        cin = (op == op_addc) ? flags_in.c : 1'b0;
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        result.flags = flags_in;
        result.value = a;
        unique case (op)
            op_add, op_addc: begin
                // RULE6 carry in summed
                result.value = sum[7:0];
                result.flags.c = sum[8];
                // RULE11 digit carry from bit 3
                result.flags.dc = low_sum[4];
                result.flags.z = (sum[7:0] == 8'h00);
            end
            op_and: begin
                // RULE8 only zero changes
                result.value = a & b;
                result.flags.z = ((a & b) == 8'h00);
            end
            op_asr: begin
                // RULE10 sign bit kept
                result.value = {b[7], b[7:1]};
                // RULE9 bit 0 to carry
                result.flags.c = b[0];
                // RULE11 zero on null result
                result.flags.z = ({b[7], b[7:1]} == 8'h00);
            end
            op_none, op_ptr: begin
                result.value = a;
            end
        endcase
    end
endmodule : byte_alu
`default_nettype wire

// ---- verification/add_shift_datapath_chk.sv ----
/* port checker for add_shift_datapath.
 assumes it is bound to the datapath and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module add_shift_datapath_chk
    import alu_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    input wire file_wr_s file_wr,
    input wire logic [7:0] accumulator,
    input wire flags_s flags,
    input wire logic [15:0] indirect_pointer_0,
    input wire logic [15:0] indirect_pointer_1,
    input wire logic stall,
    input wire logic done
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // words seen during a stall are ignored
    wire logic go = instr_valid && !stall;
    wire logic [5:0] opc = instr[13:8];
    wire logic [7:0] lit = instr[7:0];
    wire logic [6:0] fa = instr[6:0];
    wire logic [15:0] ofs = {{10{instr[5]}}, instr[5:0]};
    wire logic pop = instr[13:7] == `ALU_OPC_PTROFS;
    wire logic fop = opc inside {`ALU_OPC_ADDF, `ALU_OPC_ADDFC, `ALU_OPC_ANDF, `ALU_OPC_ARITH_SHIFT_RIGHT_OP};
    wire logic ind = fop && fa[6:1] == 6'h00;
    wire logic [1:0] cdc = {flags.c, flags.dc};
    wire logic rd0 = file_rdata[0];
    wire logic rd7 = file_rdata[7];
    a_addlit_sum: assert property (go && opc == `ALU_OPC_ADDLIT |=> done &&
        accumulator == 8'($past(accumulator) + $past(lit))) else $error("literal sum wrong");
    a_andlit_keep: assert property (go && opc == `ALU_OPC_ANDLIT |=>
        accumulator == ($past(accumulator) & $past(lit)) && cdc == $past(cdc)) else $error("literal and wrong");
    a_ptr_wrap: assert property (go && pop && !instr[6] |=>
        indirect_pointer_0 == 16'($past(indirect_pointer_0) + $past(ofs))) else $error("pointer sum wrong");
    a_ptr_flags: assert property (go && pop |=> $stable(flags))
        else $error("pointer op touched flags");
    a_zero_track: assert property (done && file_wr.we |-> flags.z == (file_wr.data == 8'h00))
        else $error("zero flag wrong");
    a_dest_file: assert property (go && fop && !ind && instr[7] |=>
        file_wr.we && file_wr.addr == $past(fa) && $stable(accumulator)) else $error("file route wrong");
    a_indirect_wait: assert property (go && ind && (fa[0] ? indirect_pointer_1[15] : indirect_pointer_0[15])
        |=> stall && !done ##1 done) else $error("extra cycle wrong");
    a_asr_sign: assert property (go && opc == `ALU_OPC_ARITH_SHIFT_RIGHT_OP && !ind |=> flags.c == $past(rd0) &&
        (!file_wr.we || file_wr.data[7] == $past(rd7))) else $error("shift wrong");
    c_stall: cover property (stall);
    c_write: cover property (file_wr.we);
    c_wrap: cover property (done && indirect_pointer_0 == 16'hffff);
endmodule : add_shift_datapath_chk
bind add_shift_datapath add_shift_datapath_chk i_chk (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .file_wr(file_wr), .accumulator(accumulator), .flags(flags),
    .indirect_pointer_0(indirect_pointer_0), .indirect_pointer_1(indirect_pointer_1), .stall(stall), .done(done));
`default_nettype wire

// ---- verification/tb_add_shift_datapath.sv ----
/* bench for add_shift_datapath.
 the bench plays the core: it presents words and the file read data. */
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module tb_add_shift_datapath
    import alu_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, stall, done;
    logic [13:0] instr = 14'h0000;
    logic [7:0] file_rdata = 8'h00, accumulator;
    logic [15:0] indirect_pointer_0, indirect_pointer_1;
    file_wr_s file_wr;
    flags_s flags;
    int n_errors = 0, n_compared = 0, cyc = 0, lat;
    add_shift_datapath i_add_shift_datapath (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr(instr), .file_rdata(file_rdata), .file_wr(file_wr), .accumulator(accumulator), .flags(flags),
        .indirect_pointer_0(indirect_pointer_0), .indirect_pointer_1(indirect_pointer_1), .stall(stall), .done(done));
    initial forever #5 clk = ~clk;
    // hang guard, far above the few dozen cycles needed
    always @(posedge clk) begin
        if (++cyc == 400) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one word, read data held through any stall, then result check
    task automatic t(input logic [13:0] w, input logic [7:0] rd, input logic [7:0] a, input logic [2:0] f,
        input logic [15:0] wr, input logic [2:0] l);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        file_rdata <= rd;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        lat = 0;
        while (done !== 1'b1 && lat < 4) begin
            @(posedge clk);
            #1;
            lat++;
        end
        chk("latency", 16'(l), 16'(lat));
        chk("accumulator", 16'(a), 16'(accumulator));
        chk("flags", 16'(f), 16'(flags));
        chk("file_wr", wr[15] ? wr : 16'h0000, wr[15] ? file_wr : 16'(file_wr.we));
    endtask : t
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("reset_state", 16'h0000, {accumulator, 5'h00, flags});
        t({`ALU_OPC_ADDLIT, 8'h8f}, 8'h00, 8'h8f, 3'b000, 16'h0000, 3'd0);
        t({`ALU_OPC_ADDLIT, 8'h71}, 8'h00, 8'h00, 3'b111, 16'h0000, 3'd0);
        t({`ALU_OPC_ADDFC, 1'b0, 7'h20}, 8'h0e, 8'h0f, 3'b000, 16'h0000, 3'd0);
        t({`ALU_OPC_ADDF, 1'b1, 7'h21}, 8'h01, 8'h0f, 3'b010, 16'ha110, 3'd0);
        t({`ALU_OPC_ANDLIT, 8'hf0}, 8'h00, 8'h00, 3'b011, 16'h0000, 3'd0);
        t({`ALU_OPC_ADDLIT, 8'hff}, 8'h00, 8'hff, 3'b000, 16'h0000, 3'd0);
        t({`ALU_OPC_ANDF, 1'b1, 7'h22}, 8'h3c, 8'hff, 3'b000, 16'ha23c, 3'd0);
        t({`ALU_OPC_ARITH_SHIFT_RIGHT_OP, 1'b0, 7'h23}, 8'h81, 8'hc0, 3'b100, 16'h0000, 3'd0);
        t({`ALU_OPC_ARITH_SHIFT_RIGHT_OP, 1'b1, 7'h24}, 8'h01, 8'hc0, 3'b101, 16'ha400, 3'd0);
        t({`ALU_OPC_PTROFS, 1'b1, 6'h1f}, 8'h00, 8'hc0, 3'b101, 16'h0000, 3'd0);
        chk("pointer_1", 16'h001f, indirect_pointer_1);
        t({`ALU_OPC_PTROFS, 1'b0, 6'h3f}, 8'h00, 8'hc0, 3'b101, 16'h0000, 3'd0);
        chk("pointer_0", 16'hffff, indirect_pointer_0);
        t({`ALU_OPC_ADDF, 1'b0, 7'h00}, 8'h01, 8'hc1, 3'b000, 16'h0000, 3'd1);
        t({`ALU_OPC_PTROFS, 1'b0, 6'h01}, 8'h00, 8'hc1, 3'b000, 16'h0000, 3'd0);
        chk("pointer_0", 16'h0000, indirect_pointer_0);
        t({`ALU_OPC_ANDF, 1'b0, 7'h01}, 8'h0f, 8'h01, 3'b000, 16'h0000, 3'd0);
        t(14'h0000, 8'h00, 8'h01, 3'b000, 16'h0000, 3'd4);
        tally_and_finish();
    end
endmodule : tb_add_shift_datapath
`default_nettype wire
